// [core/sdf_pkg.sv]
// Constants shared by the filter device, its host controller and the link.
// Assumes one 100 MHz system clock and a synchronous active-high reset.
package sdf_pkg;
  // Decimation ratios
  localparam int unsigned RATIO_S3_A    = 26667;
  localparam int unsigned RATIO_S3_B    = 32000;
  localparam int unsigned RATIO_CASC_S3 = 32000;
  localparam int unsigned RATIO_S1_LO   = 3;
  localparam int unsigned RATIO_S1_HI   = 5;
  // Converter clock expected per speed mode, in kHz
  localparam int unsigned CLK_HS_KHZ = 25600;
  localparam int unsigned CLK_LS_KHZ = 3200;
  // Cycles spent in the wake state, after the one reset-state cycle, before the port answers
  localparam int unsigned PORT_READY_CYC = 16;
  // Link register addresses
  localparam logic [1:0] LNK_STATUS = 2'h0;
  localparam logic [1:0] LNK_CFG1   = 2'h1;
  localparam logic [1:0] LNK_CFG2   = 2'h2;
  // Field positions
  localparam int unsigned CFG1_CM_BIT    = 0;
  localparam int unsigned CFG2_SPEED_BIT = 0;
  localparam int unsigned CFG2_FILT_LSB  = 1;
  localparam int unsigned CFG2_S1_BIT    = 3;
  localparam int unsigned STAT_POR_BIT   = 0;
  localparam int unsigned STAT_ALV_BIT   = 1;
  localparam int unsigned CTRL_START_BIT = 0;
  // Reset values
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h01;
  // Filter selections in configuration_two
  localparam logic [1:0] FILT_S3_A = 2'h0;
  localparam logic [1:0] FILT_S3_B = 2'h1;
  localparam logic [1:0] FILT_CASC = 2'h2;
  // Output slice tops for sinc3 alone and for the cascade
  localparam int unsigned S3_MSB   = 45;
  localparam int unsigned CASC_MSB = 48;
  // Host Wishbone byte offsets
  localparam logic [7:0] WB_CFG1 = 8'h00;
  localparam logic [7:0] WB_CFG2 = 8'h04;
  localparam logic [7:0] WB_STAT = 8'h08;
  localparam logic [7:0] WB_DATA = 8'h0C;
  localparam logic [7:0] WB_CTRL = 8'h10;

  typedef enum logic [2:0] {
    DEV_RST  = 3'b001,
    DEV_WAKE = 3'b010,
    DEV_RUN  = 3'b100
  } sdf_dev_st_t;
endpackage : sdf_pkg

// [core/sdf_link_if.sv]
// Link between the filter device and its host controller.
// Assumes both ends share clk; no clocking block, the bench joins the ends.
`timescale 1ns/1ns
interface sdf_link_if #(parameter int DW = 24) ();
  logic          cfg_we;
  logic [1:0]    cfg_addr;
  logic [7:0]    cfg_wdata;
  logic          start;
  logic [1:0]    status;
  logic          conversion_done_n;
  logic [DW-1:0] sample;
  logic          sample_valid;
  logic          sample_ready;

  modport dev  (input cfg_we, cfg_addr, cfg_wdata, start, sample_ready,
                output status, conversion_done_n, sample, sample_valid);
  modport host (output cfg_we, cfg_addr, cfg_wdata, start, sample_ready,
                input status, conversion_done_n, sample, sample_valid);
endinterface : sdf_link_if

// [core/sdf_device.sv]
// Filter device end: sinc3 and sinc3+sinc1 decimator, supply reset, status.
// Assumes modulator bits arrive with valid/ready in the clk domain.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ns
module sdf_fifo
  import sdf_pkg::*;
#(
  parameter int W = 24,
  parameter int D = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  initial if (D < 2 || (1 << AW) != D) $error("D must be a power of two");

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } sdf_fifo_t;
  sdf_fifo_t s_reg, s_next;

  logic push, pop;
  assign in_ready_o  = (s_reg.cnt != (AW+1)'(D));
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o  = s_reg.mem[s_reg.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data_i;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (pop) s_next.rd = s_reg.rd + 1'b1;
    if (push && !pop) s_next.cnt = s_reg.cnt + 1'b1;
    else if (pop && !push) s_next.cnt = s_reg.cnt - 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) s_reg <= '0;
    else s_reg <= s_next;
  end
endmodule : sdf_fifo

// Overview of operation
// - Sinc3 ratio 26667 gives 480/60 SPS
// - Sinc3 ratio 32000 gives 400/50 SPS
// - Cascade sinc3 stage fixed at 32000
// - Sinc1 stage ratio only 3 or 5
// - Full reset on I/O supply power-up
// - Analog supply cycling never resets logic
// - Reset held until I/O and regulator good
// - Done line rises once port is ready
// - Start high at release converts at once
// - Sticky power-on flag, write one clears
// - Any analog monitor low sets undervoltage flag
// - Host writes one to clear undervoltage
// - Low I/O supply also sets undervoltage
// - Common-mode output only when enabled
// - Speed bit picks high or low speed
// - Converter clock 25.6 or 3.2 MHz
// - Any reset restores all defaults
module sdf_device
  import sdf_pkg::*;
#(
  parameter int OW    = 24,
  parameter int DEPTH = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Link to host
  sdf_link_if.dev         link,
  // Modulator stream
  input  wire logic       mod_valid_i,
  input  wire logic       mod_bit_i,
  output logic            mod_ready_o,
  // Supply monitors, high when above threshold
  input  wire logic       io_supply_ok_i,
  input  wire logic       digital_regulator_ok_i,
  input  wire logic [3:0] analog_ok_i,
  // Analog controls
  output logic            common_mode_out_enable_o,
  output logic            clock_high_speed_o
);
  localparam int AW = 52;
  initial if (OW < 8 || OW > S3_MSB + 1) $error("OW out of range");

  typedef struct packed {
    sdf_dev_st_t    st;
    logic [7:0]     wake;
    logic [7:0]     cfg1;
    logic [7:0]     cfg2;
    logic           por;
    logic           alv;
    logic           conv;
    logic [AW-1:0]  i1, i2, i3;
    logic [AW-1:0]  d1, d2, d3;
    logic [15:0]    dcnt;
    logic [2:0]     s1cnt;
    logic [AW-1:0]  s1acc;
    logic           done_n;
    logic           out_valid;
    logic [OW-1:0]  out_word;
  } sdf_dev_t;
  sdf_dev_t s_reg, s_next;

  logic          rst_int;
  logic          fifo_ready;
  logic          take;
  logic [15:0]   s3_ratio;
  logic [2:0]    s1_ratio;
  logic [1:0]    filt;
  logic [AW-1:0] c1, c2, c3, inc;

  // Analog monitors stay out of this term so their dips keep all state but the undervoltage flag
  assign rst_int = rst_i || !io_supply_ok_i || !digital_regulator_ok_i;
  assign filt    = s_reg.cfg2[CFG2_FILT_LSB +: 2];

  always_comb begin
    if (filt == FILT_S3_A) s3_ratio = 16'(RATIO_S3_A);
    else if (filt == FILT_CASC) s3_ratio = 16'(RATIO_CASC_S3);
    else s3_ratio = 16'(RATIO_S3_B);
    // One bit can only encode the two legal sinc1 ratios
    s1_ratio = s_reg.cfg2[CFG2_S1_BIT] ? 3'(RATIO_S1_HI) : 3'(RATIO_S1_LO);
  end

  // One pending word at most, so a sample is taken only with room behind it
  assign take = s_reg.conv && mod_valid_i && fifo_ready && !s_reg.out_valid;

  always_comb begin
    s_next = s_reg;
    s_next.out_valid = 1'b0;
    s_next.done_n    = 1'b1;
    inc = mod_bit_i ? AW'(1) : {AW{1'b1}};
    c1 = s_reg.i3 - s_reg.d1;
    c2 = c1 - s_reg.d2;
    c3 = c2 - s_reg.d3;
    case (s_reg.st)
      DEV_RST: begin
        s_next.st = DEV_WAKE;
        s_next.done_n = 1'b0;
      end
      DEV_WAKE: begin
        s_next.done_n = 1'b0;
        s_next.wake = s_reg.wake + 1'b1;
        if (s_reg.wake == 8'(PORT_READY_CYC - 1)) begin
          s_next.st = DEV_RUN;
          s_next.conv = link.start;
        end
      end
      DEV_RUN: begin
        s_next.conv = link.start;
        if (take) begin
          s_next.i1 = s_reg.i1 + inc;
          s_next.i2 = s_reg.i2 + s_reg.i1;
          s_next.i3 = s_reg.i3 + s_reg.i2;
          s_next.dcnt = s_reg.dcnt + 1'b1;
          if (s_reg.dcnt == s3_ratio - 1'b1) begin
            s_next.dcnt = '0;
            s_next.d1 = s_reg.i3;
            s_next.d2 = c1;
            s_next.d3 = c2;
            if (filt == FILT_CASC) begin
              s_next.s1acc = s_reg.s1acc + c3;
              s_next.s1cnt = s_reg.s1cnt + 1'b1;
              if (s_reg.s1cnt == s1_ratio - 1'b1) begin
                // Word is cut from the full sum before the clear
                s_next.out_word = s_next.s1acc[CASC_MSB -: OW];
                s_next.s1cnt = '0;
                s_next.s1acc = '0;
                s_next.out_valid = 1'b1;
              end
            end else begin
              s_next.out_valid = 1'b1;
              s_next.out_word = c3[S3_MSB -: OW];
            end
          end
        end
        // Conversion done pulses low once per word
        if (s_reg.out_valid) s_next.done_n = 1'b0;
        if (link.cfg_we) begin
          if (link.cfg_addr == LNK_CFG1) s_next.cfg1 = link.cfg_wdata;
          else if (link.cfg_addr == LNK_CFG2) s_next.cfg2 = link.cfg_wdata;
          if (link.cfg_addr == LNK_STATUS) begin
            if (link.cfg_wdata[STAT_POR_BIT]) s_next.por = 1'b0;
            if (link.cfg_wdata[STAT_ALV_BIT]) s_next.alv = 1'b0;
          end else begin
            // New settings restart the filter from empty
            s_next.i1 = '0; s_next.i2 = '0; s_next.i3 = '0;
            s_next.d1 = '0; s_next.d2 = '0; s_next.d3 = '0;
            s_next.dcnt = '0; s_next.s1cnt = '0; s_next.s1acc = '0;
          end
        end
      end
      default: s_next.st = DEV_RST;
    endcase
    // Set wins over a clear in the same cycle
    if (analog_ok_i != 4'hF) s_next.alv = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_int) begin
      s_reg        <= '0;
      s_reg.st     <= DEV_RST;
      s_reg.cfg1   <= CFG1_RST;
      s_reg.cfg2   <= CFG2_RST;
      s_reg.done_n <= 1'b0;
      s_reg.por    <= 1'b1;
      s_reg.alv    <= !io_supply_ok_i || (analog_ok_i != 4'hF);
    end else begin
      s_reg <= s_next;
    end
  end

  sdf_fifo #(.W(OW), .D(DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_int),
    .in_valid_i  (s_reg.out_valid),
    .in_ready_o  (fifo_ready),
    .in_data_i   (s_reg.out_word),
    .out_valid_o (link.sample_valid),
    .out_ready_i (link.sample_ready),
    .out_data_o  (link.sample)
  );

  assign mod_ready_o = s_reg.conv && fifo_ready && !s_reg.out_valid;
  assign link.status[STAT_POR_BIT] = s_reg.por;
  assign link.status[STAT_ALV_BIT] = s_reg.alv;
  assign link.conversion_done_n = s_reg.done_n;
  assign common_mode_out_enable_o = s_reg.cfg1[CFG1_CM_BIT];
  // Selects the 25.6 MHz source when high, 3.2 MHz when low
  assign clock_high_speed_o = s_reg.cfg2[CFG2_SPEED_BIT];
endmodule : sdf_device

// [core/sdf_host.sv]
// Host controller end: Wishbone slave for software, drives the link.
// Assumes classic single Wishbone cycles on the same clk.
`timescale 1ns/1ns
module sdf_host
  import sdf_pkg::*;
#(
  parameter int DW = 24
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Link to device
  sdf_link_if.host         link,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  initial if (DW > 32 || DW < 1) $error("DW must fit a bus word");

  typedef struct packed {
    logic          up;
    logic          pend;
    logic [1:0]    pend_addr;
    logic [7:0]    pend_data;
    logic [7:0]    cfg1;
    logic [7:0]    cfg2;
    logic          start;
    logic          ack;
    logic [31:0]   dat;
    logic          we;
    logic [1:0]    addr;
    logic [7:0]    wdata;
    logic [DW-1:0] smp;
    logic          smp_valid;
    logic          rdy;
  } sdf_host_t;
  sdf_host_t s_reg, s_next;

  logic req, wr0;
  assign req = wb_cyc_i && wb_stb_i && !s_reg.ack;
  assign wr0 = wb_we_i && wb_sel_i[0];

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.we  = 1'b0;
    // Port counts as up once the done line has been seen high
    if (link.conversion_done_n) s_next.up = 1'b1;
    if (link.sample_valid && s_reg.rdy) begin
      s_next.smp = link.sample;
      s_next.smp_valid = 1'b1;
    end
    if (s_reg.pend && s_reg.up) begin
      s_next.we = 1'b1;
      s_next.addr = s_reg.pend_addr;
      s_next.wdata = s_reg.pend_data;
      s_next.pend = 1'b0;
    end
    if (req) begin
      s_next.dat = '0;
      if (wb_adr_i == WB_CFG1 || wb_adr_i == WB_CFG2 || wb_adr_i == WB_STAT) begin
        // A write waits while an earlier one is still queued
        if (!wb_we_i) begin
          s_next.ack = 1'b1;
          if (wb_adr_i == WB_CFG1) s_next.dat[7:0] = s_reg.cfg1;
          else if (wb_adr_i == WB_CFG2) s_next.dat[7:0] = s_reg.cfg2;
          else s_next.dat[3:0] = {s_reg.smp_valid, s_reg.up, link.status};
        end else if (!s_reg.pend) begin
          s_next.ack = 1'b1;
          if (wr0) begin
            s_next.pend = 1'b1;
            s_next.pend_data = wb_dat_i[7:0];
            if (wb_adr_i == WB_CFG1) begin
              s_next.pend_addr = LNK_CFG1;
              s_next.cfg1 = wb_dat_i[7:0];
            end else if (wb_adr_i == WB_CFG2) begin
              s_next.pend_addr = LNK_CFG2;
              // Only the two legal sinc1 ratios are encodable
              s_next.cfg2 = wb_dat_i[7:0];
            end else begin
              s_next.pend_addr = LNK_STATUS;
            end
          end
        end
      end else if (wb_adr_i == WB_DATA) begin
        s_next.ack = 1'b1;
        if (!wb_we_i) begin
          s_next.dat[DW-1:0] = s_reg.smp;
          // Pop only a held word, so a word taken this cycle survives
          if (s_reg.smp_valid) s_next.smp_valid = 1'b0;
        end
      end else if (wb_adr_i == WB_CTRL) begin
        s_next.ack = 1'b1;
        if (!wb_we_i) s_next.dat[CTRL_START_BIT] = s_reg.start;
        else if (wr0) s_next.start = wb_dat_i[CTRL_START_BIT];
      end else begin
        s_next.ack = 1'b1;
      end
    end
    s_next.rdy = !s_next.smp_valid;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg      <= '0;
      s_reg.cfg1 <= CFG1_RST;
      s_reg.cfg2 <= CFG2_RST;
      s_reg.rdy  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o          = s_reg.ack;
  assign wb_dat_o          = s_reg.dat;
  assign link.cfg_we       = s_reg.we;
  assign link.cfg_addr     = s_reg.addr;
  assign link.cfg_wdata    = s_reg.wdata;
  assign link.start        = s_reg.start;
  assign link.sample_ready = s_reg.rdy;
endmodule : sdf_host

// [testbench/sdf_link_checker.sv]
// Checker on the device-host link; sees the link signals only.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ns
module sdf_link_checker
  import sdf_pkg::*;
#(
  parameter int DW = 24
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          cfg_we,
  input  wire logic [1:0]    cfg_addr,
  input  wire logic [7:0]    cfg_wdata,
  input  wire logic          start,
  input  wire logic [1:0]    status,
  input  wire logic          conversion_done_n,
  input  wire logic [DW-1:0] sample,
  input  wire logic          sample_valid,
  input  wire logic          sample_ready
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_wake_done_low: assert property ($fell(rst_i) |-> !conversion_done_n [*8])
    else $error("done line high too soon after reset");
  a_port_up_bound: assert property ($fell(rst_i) |-> ##[1:40] conversion_done_n)
    else $error("done line never rose after reset");
  a_no_early_write: assert property ($fell(rst_i) |-> !cfg_we [*8])
    else $error("link write before port ready");
  a_reset_por_set: assert property ($fell(rst_i) |-> status[STAT_POR_BIT])
    else $error("power-on flag not set by reset");
  a_start_idle: assert property ($fell(rst_i) |-> !start)
    else $error("start not cleared by reset");
  a_por_clear: assert property (cfg_we && cfg_addr == LNK_STATUS && cfg_wdata[STAT_POR_BIT]
    |=> !status[STAT_POR_BIT])
    else $error("power-on flag not cleared by write one");
  a_word_hold: assert property (sample_valid && !sample_ready
    |=> sample_valid && $stable(sample))
    else $error("output word lost while stalled");
  a_take_one: assert property (sample_valid && sample_ready |=> !sample_ready)
    else $error("host took more than one word");

  c_word_taken: cover property (sample_valid && sample_ready);
  c_done_pulse: cover property ($fell(conversion_done_n));
  c_status_write: cover property (cfg_we && cfg_addr == LNK_STATUS);
endmodule : sdf_link_checker

// [testbench/sinc3_decimator_and_supply_status_test.sv]
// Bench: device and host joined by the link, driven over Wishbone.
// Assumes package, interface and both ends compile first.
`timescale 1ns/1ns
module sinc3_decimator_and_supply_status_test;
  import sdf_pkg::*;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic        mod_valid, mod_bit, mod_ready, io_ok, dreg_ok, cm_en, hs_clk;
  logic [3:0]  analog_ok, wb_sel;
  logic [5:0]  gap_cnt;
  int          n_errors, n_compared;

  sdf_link_if #(.DW(24)) link ();
  sdf_device #(.OW(24), .DEPTH(4)) i_sdf_device (
    .clk_i(clk_i), .rst_i(rst_i), .link(link), .mod_valid_i(mod_valid),
    .mod_bit_i(mod_bit), .mod_ready_o(mod_ready), .io_supply_ok_i(io_ok),
    .digital_regulator_ok_i(dreg_ok), .analog_ok_i(analog_ok),
    .common_mode_out_enable_o(cm_en), .clock_high_speed_o(hs_clk));
  sdf_host #(.DW(24)) i_sdf_host (
    .clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  sdf_link_checker #(.DW(24)) i_sdf_link_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_we(link.cfg_we), .cfg_addr(link.cfg_addr),
    .cfg_wdata(link.cfg_wdata), .start(link.start), .status(link.status),
    .conversion_done_n(link.conversion_done_n), .sample(link.sample),
    .sample_valid(link.sample_valid), .sample_ready(link.sample_ready));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Toggling input keeps the filter datapath busy
  always @(posedge clk_i) mod_bit <= ~mod_bit;

  // One idle cycle in 64 exercises the valid qualifier at small cost
  always @(posedge clk_i) begin
    gap_cnt   <= rst_i ? 6'h00 : gap_cnt + 6'h01;
    mod_valid <= rst_i || (gap_cnt != 6'h3F);
  end

  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic fail();
    n_errors++;
    wrap_up();
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request stands until the edge that samples ack high, then is released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 500);
    if (k >= 500) fail();
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_up();
    int k;
    k = 0;
    while (link.conversion_done_n !== 1'b1 && k < 100) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 100) fail();
  endtask : wait_up

  task automatic t_wake();
    int k;
    k = 0;
    while (link.conversion_done_n !== 1'b1 && k < 60) begin
      @(negedge clk_i);
      k++;
    end
    chk(32'(k inside {18, 19}), 32'h1);
    rdchk(WB_CFG1, 32'(CFG1_RST));
    rdchk(WB_CFG2, 32'(CFG2_RST));
    rdchk(WB_STAT, 32'h5);
    wb(1'b1, 8'h20, 32'hFF);
    rdchk(8'h20, 32'h0);
  endtask : t_wake

  task automatic t_cfg();
    logic [7:0] v[5] = '{8'h01, 8'h00, 8'h03, 8'h05, 8'h0D};
    foreach (v[i]) begin
      wb(1'b1, WB_CFG2, 32'(v[i]));
      repeat (4) @(posedge clk_i);
      chk(32'(hs_clk), 32'(v[i][0]));
      rdchk(WB_CFG2, 32'(v[i]));
    end
    wb(1'b1, WB_CFG1, 32'h1);
    repeat (4) @(posedge clk_i);
    chk(32'(cm_en), 32'h1);
    // Lane 0 off: the write is acked but must not land
    wb_sel <= 4'h0;
    wb(1'b1, WB_CFG1, 32'h0);
    wb_sel <= 4'hF;
    repeat (4) @(posedge clk_i);
    chk(32'(cm_en), 32'h1);
    rdchk(WB_CFG1, 32'h1);
  endtask : t_cfg

  task automatic t_supply();
    wb(1'b1, WB_STAT, 32'h1);
    repeat (5) @(posedge clk_i);
    rdchk(WB_STAT, 32'h4);
    for (int i = 0; i < 4; i++) begin
      analog_ok[i] <= 1'b0;
      repeat (3) @(posedge clk_i);
      analog_ok[i] <= 1'b1;
      rdchk(WB_STAT, 32'h6);
      wb(1'b1, WB_STAT, 32'h2);
      repeat (5) @(posedge clk_i);
      rdchk(WB_STAT, 32'h4);
    end
    chk(32'(cm_en), 32'h1);
    io_ok <= 1'b0;
    repeat (3) @(posedge clk_i);
    io_ok <= 1'b1;
    wait_up();
    rdchk(WB_STAT, 32'h7);
    chk(32'(cm_en), 32'h0);
    @(posedge clk_i);
    dreg_ok <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (i > 1) chk(32'(link.conversion_done_n), 32'h0);
    end
    @(posedge clk_i);
    dreg_ok <= 1'b1;
    wait_up();
    wb(1'b1, WB_STAT, 32'h3);
    repeat (5) @(posedge clk_i);
    rdchk(WB_STAT, 32'h4);
  endtask : t_supply

  // First word may include one bit of slack; later words are exact
  task automatic t_conv(input logic [7:0] cfg, input int ratio, input int words);
    int n;
    int k;
    wb(1'b1, WB_CTRL, 32'h0);
    wb(1'b1, WB_CFG2, 32'(cfg));
    repeat (5) @(posedge clk_i);
    wb(1'b1, WB_CTRL, 32'h1);
    n = 0;
    for (int w = 0; w < words; w++) begin
      k = 0;
      while (k < 40000) begin
        @(negedge clk_i);
        k++;
        if (link.conversion_done_n === 1'b0) break;
        if (mod_valid && mod_ready) n++;
      end
      if (k >= 40000) fail();
      if (w > 0) chk(32'(n), 32'(ratio));
      else chk(32'(n >= ratio && n <= ratio + 1), 32'h1);
      // Bit seen in the done cycle is the next word's first
      n = (mod_valid && mod_ready) ? 1 : 0;
    end
    wb(1'b1, WB_CTRL, 32'h0);
  endtask : t_conv

  task automatic t_drain();
    int k;
    k = 0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, WB_STAT, 32'h0);
    while (rd[3] === 1'b1 && k < 8) begin
      wb(1'b0, WB_DATA, 32'h0);
      k++;
      repeat (3) @(posedge clk_i);
      wb(1'b0, WB_STAT, 32'h0);
    end
    chk(32'(k), 32'h2);
  endtask : t_drain

  initial begin
    rst_i     = 1'b1;
    wb_cyc    = 1'b0;
    wb_stb    = 1'b0;
    wb_we     = 1'b0;
    wb_adr    = 8'h00;
    wb_wdat   = 32'h0;
    wb_sel    = 4'hF;
    mod_bit   = 1'b0;
    io_ok     = 1'b1;
    dreg_ok   = 1'b1;
    analog_ok = 4'hF;
    n_errors  = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_wake();
    t_cfg();
    t_supply();
    t_conv(8'h01, RATIO_S3_A, 2);
    t_drain();
    t_conv(8'h03, RATIO_S3_B, 1);
    wrap_up();
  end
endmodule : sinc3_decimator_and_supply_status_test
